/* File: logic/muldiv_pkg.sv */
// Purpose: Shared constants and types for the multiply/divide unit and its host.
// Assumes: Both ends run on the same 25 MHz system clock.
// Notes: Times are counted in system clock periods.
package muldiv_pkg;

  // Device bus map: indices 0 to 5 are the data bytes, 6 is the status.
  localparam int N_DATA = 6;
  localparam logic [2:0] IDX_STATUS = 3'h6;
  localparam int STAT_ERR_BIT = 7;
  localparam int STAT_OV_BIT = 6;
  localparam logic [1:0] STAT_RESET = 2'h0;

  // Calculation times in system clock periods.
  localparam int CYC_DIV32 = 17;
  localparam int CYC_DIV16 = 9;
  localparam int CYC_MUL = 11;
  localparam int CNT_W = 5;

  localparam int NBYTES_DIV32 = 6;
  localparam int NBYTES_SHORT = 4;

  typedef enum logic [1:0] {
    OP_DIV32 = 2'h0,
    OP_DIV16 = 2'h1,
    OP_MUL = 2'h2
  } op_t;

  // Host-side register map (word indices) and fields.
  localparam logic [2:0] HREG_CTRL = 3'h0;
  localparam logic [2:0] HREG_OPA = 3'h1;
  localparam logic [2:0] HREG_OPB = 3'h2;
  localparam logic [2:0] HREG_STAT = 3'h3;
  localparam logic [2:0] HREG_RES = 3'h4;
  localparam logic [2:0] HREG_REM = 3'h5;
  localparam int CTRL_GO_BIT = 8;
  localparam int HSTAT_BUSY_BIT = 0;
  localparam int HSTAT_DONE_BIT = 1;
  localparam int HSTAT_ERR_BIT = 2;
  localparam int HSTAT_OV_BIT = 3;

  function automatic logic [CNT_W-1:0] op_cycles(input op_t op);
    case (op)
      OP_DIV32: op_cycles = CNT_W'(CYC_DIV32);
      OP_DIV16: op_cycles = CNT_W'(CYC_DIV16);
      default: op_cycles = CNT_W'(CYC_MUL);
    endcase
  endfunction

endpackage

/* File: logic/muldiv_bus_if.sv */
// Purpose: Internal register bus between the processor side and the unit.
// Assumes: Read data stand in the cycle after the read strobe.
// Notes: No clocking block; both ends clock on the same system clock.
interface muldiv_bus_if;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;

  modport dev_mp (
    input addr,
    input wdata,
    input wr,
    input rd,
    output rdata
  );

  modport host_mp (
    output addr,
    output wdata,
    output wr,
    output rd,
    input rdata
  );
endinterface

/* File: logic/muldiv_unit.sv */
// Purpose: Multiply/divide coprocessor with six byte data registers and a status register.
// Assumes: The host keeps the write orders and stays off the data bytes while busy.
// Notes: Data bytes have no reset; results are written back into the same bytes.
module muldiv_unit
  import muldiv_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  muldiv_bus_if.dev_mp bus,
  output logic o_busy,
  output logic o_access_error,
  output logic o_overflow
);

  typedef enum logic [8:0] {
    TR_IDLE = 9'h001,
    TR_A0 = 9'h002,
    TR_A01 = 9'h004,
    TR_A012 = 9'h008,
    TR_A0123 = 9'h010,
    TR_A01234 = 9'h020,
    TR_A014 = 9'h040,
    TR_A04 = 9'h080,
    TR_A041 = 9'h100
  } track_t;

  logic [7:0] data_reg [N_DATA];
  track_t track_reg;
  track_t track_next;
  logic busy_reg;
  logic [CNT_W-1:0] cnt_reg;
  op_t op_reg;
  logic err_reg;
  logic ov_reg;
  logic [7:0] rdata_reg;

  logic data_sel;
  logic data_wr;
  logic data_rd;
  logic wr_ok;
  logic start;
  op_t start_op;
  logic finish;

  logic [31:0] dividend;
  logic [15:0] divisor;
  logic [31:0] quotient;
  logic [15:0] remainder;
  logic [31:0] product;
  logic [7:0] res_byte [N_DATA];
  logic [N_DATA-1:0] res_we;
  logic ov_new;

  assign data_sel = bus.addr < 3'(N_DATA);
  assign data_wr = bus.wr && data_sel;
  assign data_rd = bus.rd && data_sel;
  // Writes that land while busy are dropped so the operands stay intact.
  assign wr_ok = data_wr && !busy_reg;
  assign finish = busy_reg && (cnt_reg == '0);

  // Order tracker. Only data writes move it, so reads, status accesses and
  // idle cycles between the writes leave a partial order in place.
  always_comb begin
    track_next = track_reg;
    start = 1'b0;
    start_op = OP_DIV32;
    if (wr_ok) begin
      if (bus.addr == 3'h0) begin
        track_next = TR_A0;
      end else begin
        track_next = TR_IDLE;
        case (track_reg)
          TR_A0: begin
            if (bus.addr == 3'h1) begin
              track_next = TR_A01;
            end else if (bus.addr == 3'h4) begin
              track_next = TR_A04;
            end
          end
          TR_A01: begin
            if (bus.addr == 3'h2) begin
              track_next = TR_A012;
            end else if (bus.addr == 3'h4) begin
              track_next = TR_A014;
            end
          end
          TR_A012: begin
            if (bus.addr == 3'h3) begin
              track_next = TR_A0123;
            end
          end
          TR_A0123: begin
            if (bus.addr == 3'h4) begin
              track_next = TR_A01234;
            end
          end
          TR_A01234: begin
            if (bus.addr == 3'h5) begin
              start = 1'b1;
              start_op = OP_DIV32;
            end
          end
          TR_A014: begin
            if (bus.addr == 3'h5) begin
              start = 1'b1;
              start_op = OP_DIV16;
            end
          end
          TR_A04: begin
            if (bus.addr == 3'h1) begin
              track_next = TR_A041;
            end
          end
          TR_A041: begin
            if (bus.addr == 3'h5) begin
              start = 1'b1;
              start_op = OP_MUL;
            end
          end
          default: track_next = TR_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      track_reg <= TR_IDLE;
    end else begin
      track_reg <= track_next;
    end
  end

  // Busy counter: loaded with one less than the calculation time so that the
  // results land on the Nth edge after the starting write.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      busy_reg <= 1'b0;
      cnt_reg <= '0;
      op_reg <= OP_DIV32;
    end else if (start) begin
      busy_reg <= 1'b1;
      cnt_reg <= op_cycles(start_op) - CNT_W'(1);
      op_reg <= start_op;
    end else if (finish) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - CNT_W'(1);
    end
  end

  // Operands are taken from the byte registers at completion; they cannot
  // change meanwhile because busy writes are dropped.
  always_comb begin
    divisor = {data_reg[5], data_reg[4]};
    if (op_reg == OP_DIV32) begin
      dividend = {data_reg[3], data_reg[2], data_reg[1], data_reg[0]};
    end else begin
      dividend = {16'h0000, data_reg[1], data_reg[0]};
    end
    product = 32'({data_reg[1], data_reg[0]}) * 32'(divisor);
    if (divisor == 16'h0000) begin
      quotient = 32'hffff_ffff;
      remainder = dividend[15:0];
    end else begin
      quotient = dividend / 32'(divisor);
      remainder = 16'(dividend % 32'(divisor));
    end
  end

  always_comb begin
    res_we = '0;
    for (int i = 0; i < N_DATA; i++) begin
      res_byte[i] = 8'h00;
    end
    ov_new = 1'b0;
    case (op_reg)
      OP_MUL: begin
        ov_new = product > 32'h0000_ffff;
        res_we = 6'b00_1111;
        for (int i = 0; i < 4; i++) begin
          res_byte[i] = product[i*8 +: 8];
        end
      end
      OP_DIV16: begin
        ov_new = divisor == 16'h0000;
        res_we = 6'b11_0011;
        res_byte[0] = quotient[7:0];
        res_byte[1] = quotient[15:8];
        res_byte[4] = remainder[7:0];
        res_byte[5] = remainder[15:8];
      end
      default: begin
        ov_new = divisor == 16'h0000;
        res_we = 6'b11_1111;
        for (int i = 0; i < 4; i++) begin
          res_byte[i] = quotient[i*8 +: 8];
        end
        res_byte[4] = remainder[7:0];
        res_byte[5] = remainder[15:8];
      end
    endcase
  end

  // Data bytes carry no reset: their power-up value is undefined.
  always_ff @(posedge i_ref_clk) begin
    for (int i = 0; i < N_DATA; i++) begin
      if (finish && res_we[i]) begin
        data_reg[i] <= res_byte[i];
      end else if (wr_ok && bus.addr == 3'(i)) begin
        data_reg[i] <= bus.wdata;
      end
    end
  end

  // Error flag. Setting needs busy and clearing needs idle, so the two can
  // never meet in one cycle.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      err_reg <= STAT_RESET[1];
    end else if (busy_reg && (data_wr || data_rd)) begin
      err_reg <= 1'b1;
    end else if (bus.rd && bus.addr == IDX_STATUS && err_reg && !busy_reg) begin
      err_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ov_reg <= STAT_RESET[0];
    end else if (finish) begin
      ov_reg <= ov_new;
    end
  end

  // Read data: status shows flags before any clear; unmapped reads give zero.
  // Data reads never disturb the bytes, so result reads may be spread out.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rdata_reg <= 8'h00;
    end else if (bus.rd) begin
      if (data_sel) begin
        rdata_reg <= data_reg[bus.addr];
      end else if (bus.addr == IDX_STATUS) begin
        rdata_reg <= 8'h00;
        rdata_reg[STAT_ERR_BIT] <= err_reg;
        rdata_reg[STAT_OV_BIT] <= ov_reg;
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end

  assign bus.rdata = rdata_reg;
  assign o_busy = busy_reg;
  assign o_access_error = err_reg;
  assign o_overflow = ov_reg;

endmodule

/* File: logic/muldiv_host.sv */
// Purpose: Processor-side sequencer that drives the unit through its byte registers.
// Assumes: Software sets operands, then writes op and the go bit in one control write.
// Notes: Result words are zero-filled where an operation returns fewer bytes.
module muldiv_host
  import muldiv_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_idle_inhibit,
  muldiv_bus_if.host_mp bus
);

  typedef enum logic [5:0] {
    H_IDLE = 6'h01,
    H_WRITE = 6'h02,
    H_WAIT = 6'h04,
    H_RD_ISSUE = 6'h08,
    H_RD_DROP = 6'h10,
    H_RD_CAP = 6'h20
  } hstate_t;

  hstate_t state_reg;
  op_t op_reg;
  logic [31:0] opa_reg;
  logic [15:0] opb_reg;
  logic [31:0] res_reg;
  logic [15:0] rem_reg;
  logic done_reg;
  logic err_reg;
  logic ov_reg;
  logic stat_phase_reg;
  logic [2:0] step_reg;
  logic [CNT_W-1:0] wait_reg;
  logic [2:0] addr_reg;
  logic [7:0] wdata_reg;
  logic wr_reg;
  logic rd_reg;
  logic [31:0] rdata_reg;
  logic [2:0] widx;
  logic [2:0] ridx;
  logic [2:0] nbytes;

  // Byte index for each step of the write order.
  function automatic logic [2:0] write_index(input op_t op, input logic [2:0] step);
    case (op)
      OP_DIV16: write_index = (step < 3'h2) ? step : step + 3'h2;
      OP_MUL: write_index = {step[0], 1'b0, step[1]};
      default: write_index = step;
    endcase
  endfunction

  always_comb begin
    nbytes = (op_reg == OP_DIV32) ? 3'(NBYTES_DIV32) : 3'(NBYTES_SHORT);
    widx = write_index(op_reg, step_reg);
    // Divisions read back in write order; the product reads 0 to 3.
    ridx = (op_reg == OP_MUL) ? step_reg : widx;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_reg <= H_IDLE;
      op_reg <= OP_DIV32;
      opa_reg <= 32'h0000_0000;
      opb_reg <= 16'h0000;
      done_reg <= 1'b0;
      stat_phase_reg <= 1'b0;
      step_reg <= 3'h0;
      wait_reg <= '0;
      addr_reg <= 3'h0;
      wdata_reg <= 8'h00;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      res_reg <= 32'h0000_0000;
      rem_reg <= 16'h0000;
      err_reg <= 1'b0;
      ov_reg <= 1'b0;
    end else begin
      case (state_reg)
        H_IDLE: begin
          if (i_wr && i_addr == HREG_OPA) begin
            opa_reg <= i_wdata;
          end
          if (i_wr && i_addr == HREG_OPB) begin
            opb_reg <= i_wdata[15:0];
          end
          if (i_wr && i_addr == HREG_CTRL) begin
            op_reg <= (i_wdata[1:0] == 2'h1) ? OP_DIV16 :
                      (i_wdata[1:0] == 2'h2) ? OP_MUL : OP_DIV32;
            if (i_wdata[CTRL_GO_BIT]) begin
              state_reg <= H_WRITE;
              step_reg <= 3'h0;
              done_reg <= 1'b0;
              res_reg <= 32'h0000_0000;
              rem_reg <= 16'h0000;
            end
          end
        end
        H_WRITE: begin
          if (step_reg == nbytes) begin
            wr_reg <= 1'b0;
            wait_reg <= op_cycles(op_reg);
            state_reg <= H_WAIT;
          end else begin
            wr_reg <= 1'b1;
            addr_reg <= widx;
            // Indices 0-3 carry operand A bytes, 4-5 operand B, low byte first.
            wdata_reg <= widx[2] ? opb_reg[widx[0]*8 +: 8] : opa_reg[widx[1:0]*8 +: 8];
            step_reg <= step_reg + 3'h1;
          end
        end
        H_WAIT: begin
          if (wait_reg == '0) begin
            stat_phase_reg <= 1'b1;
            addr_reg <= IDX_STATUS;
            rd_reg <= 1'b1;
            step_reg <= 3'h0;
            state_reg <= H_RD_DROP;
          end else begin
            wait_reg <= wait_reg - CNT_W'(1);
          end
        end
        H_RD_ISSUE: begin
          addr_reg <= ridx;
          rd_reg <= 1'b1;
          state_reg <= H_RD_DROP;
        end
        H_RD_DROP: begin
          rd_reg <= 1'b0;
          state_reg <= H_RD_CAP;
        end
        H_RD_CAP: begin
          if (stat_phase_reg) begin
            stat_phase_reg <= 1'b0;
            err_reg <= bus.rdata[STAT_ERR_BIT];
            ov_reg <= bus.rdata[STAT_OV_BIT];
            // A flagged result is not worth reading back.
            if (bus.rdata[STAT_ERR_BIT] || bus.rdata[STAT_OV_BIT]) begin
              done_reg <= 1'b1;
              state_reg <= H_IDLE;
            end else begin
              state_reg <= H_RD_ISSUE;
            end
          end else begin
            if (addr_reg[2]) begin
              rem_reg[addr_reg[0]*8 +: 8] <= bus.rdata;
            end else begin
              res_reg[addr_reg[1:0]*8 +: 8] <= bus.rdata;
            end
            if (step_reg + 3'h1 == nbytes) begin
              done_reg <= 1'b1;
              state_reg <= H_IDLE;
            end else begin
              step_reg <= step_reg + 3'h1;
              state_reg <= H_RD_ISSUE;
            end
          end
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  // Software read port, data one cycle after the strobe.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        HREG_CTRL: rdata_reg <= {30'h0, op_reg};
        HREG_OPA: rdata_reg <= opa_reg;
        HREG_OPB: rdata_reg <= {16'h0000, opb_reg};
        HREG_STAT: begin
          rdata_reg <= 32'h0000_0000;
          rdata_reg[HSTAT_BUSY_BIT] <= state_reg != H_IDLE;
          rdata_reg[HSTAT_DONE_BIT] <= done_reg;
          rdata_reg[HSTAT_ERR_BIT] <= err_reg;
          rdata_reg[HSTAT_OV_BIT] <= ov_reg;
        end
        HREG_RES: rdata_reg <= res_reg;
        HREG_REM: rdata_reg <= {16'h0000, rem_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign o_rdata = rdata_reg;
  // Sleep must wait until the unit has finished and been read out.
  assign o_idle_inhibit = state_reg != H_IDLE;
  assign bus.addr = addr_reg;
  assign bus.wdata = wdata_reg;
  assign bus.wr = wr_reg;
  assign bus.rd = rd_reg;

endmodule

/* File: verif/muldiv_unit_asserts.sv */
// Purpose: Bus and timing checks between the host sequencer and the unit.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: The expected busy length is rebuilt from the write order seen.
module muldiv_unit_asserts
  import muldiv_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic o_busy,
  input wire logic o_access_error,
  input wire logic o_overflow,
  input wire logic o_idle_inhibit
);
  logic [2:0] last_idx_reg;
  logic [2:0] prev_idx_reg;
  logic [4:0] want_len_reg;
  logic [4:0] busy_len_reg;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  // Only the two writes before the closing one tell the three orders apart.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      last_idx_reg <= 3'h0;
      prev_idx_reg <= 3'h0;
      want_len_reg <= 5'h00;
    end else if (wr && !o_busy && addr < IDX_STATUS) begin
      last_idx_reg <= addr;
      prev_idx_reg <= last_idx_reg;
      if (addr == 3'h5) begin
        want_len_reg <= (last_idx_reg == 3'h1) ? 5'(CYC_MUL) :
                        (prev_idx_reg == 3'h3) ? 5'(CYC_DIV32) : 5'(CYC_DIV16);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    busy_len_reg <= (i_rst || !o_busy) ? 5'h00 : busy_len_reg + 5'h01;
  end

  a_busy_length: assert property ($fell(o_busy) |-> busy_len_reg == want_len_reg)
    else $error("busy length does not fit the operation");
  a_start_on_last: assert property (wr && addr == 3'h5 && !o_busy |=> o_busy)
    else $error("closing write did not start the unit");
  a_start_cause: assert property ($rose(o_busy) |-> $past(wr) && $past(addr) == 3'h5)
    else $error("unit started without a closing write");
  a_status_read: assert property (rd && addr == IDX_STATUS |=>
    rdata == {$past(o_access_error), $past(o_overflow), 6'h00})
    else $error("status byte does not match the flags");
  a_rdata_hold: assert property (!rd |=> $stable(rdata))
    else $error("read data changed without a read");
  a_ov_at_end: assert property ($changed(o_overflow) |-> $past(o_busy))
    else $error("overflow changed outside a completion");
  a_keep_off: assert property (o_busy |-> !((wr || rd) && addr < IDX_STATUS))
    else $error("host touched a data byte while busy");
  a_awake_busy: assert property (o_busy |-> o_idle_inhibit)
    else $error("host allowed idle while busy");
endmodule

/* File: verif/muldiv_unit_sequenced_tb.sv */
// Purpose: Self-checking bench for the host and unit joined on one bus.
// Assumes: A second unit on its own bus is driven directly, rule breaking included.
// Notes: Expected results are computed here from the operands.
module muldiv_unit_sequenced_tb
  import muldiv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic i_ref_clk;
  logic i_rst;
  logic [2:0] i_addr;
  logic [31:0] i_wdata;
  logic i_wr, i_rd;
  logic [31:0] o_rdata;
  logic o_idle_inhibit, busy_a, err_a, ov_a, busy_b, err_b, ov_b;
  int n_errors = 0;
  int n_tests = 0;

  muldiv_bus_if bus_a();
  muldiv_bus_if bus_b();
  muldiv_host i_muldiv_host(.i_ref_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_idle_inhibit, .bus(bus_a.host_mp));
  muldiv_unit i_muldiv_unit(.i_ref_clk, .i_rst, .bus(bus_a.dev_mp), .o_busy(busy_a),
    .o_access_error(err_a), .o_overflow(ov_a));
  muldiv_unit i_muldiv_unit_b(.i_ref_clk, .i_rst, .bus(bus_b.dev_mp), .o_busy(busy_b),
    .o_access_error(err_b), .o_overflow(ov_b));
  muldiv_unit_asserts i_muldiv_unit_asserts(.i_ref_clk, .i_rst, .addr(bus_a.addr),
    .wdata(bus_a.wdata), .wr(bus_a.wr), .rd(bus_a.rd), .rdata(bus_a.rdata), .o_busy(busy_a),
    .o_access_error(err_a), .o_overflow(ov_a), .o_idle_inhibit);

  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bwr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    bus_b.addr <= a;
    bus_b.wdata <= d;
    bus_b.wr <= 1'b1;
    @(posedge i_ref_clk);
    bus_b.wr <= 1'b0;
  endtask

  task automatic brd(input logic [2:0] a, output logic [7:0] v);
    @(posedge i_ref_clk);
    bus_b.addr <= a;
    bus_b.rd <= 1'b1;
    @(posedge i_ref_clk);
    bus_b.rd <= 1'b0;
    @(negedge i_ref_clk);
    v = bus_b.rdata;
  endtask

  task automatic bchk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    brd(a, v);
    chk(32'(v), 32'(e));
  endtask

  // Counts the cycles the second unit stays busy, bounded against a hang.
  task automatic busy_len(output int n);
    n = 0;
    @(negedge i_ref_clk);
    while (busy_b === 1'b1 && n < 40) begin
      n++;
      @(negedge i_ref_clk);
    end
  endtask

  task automatic hwr(input logic [2:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  task automatic hrd(input logic [2:0] a, output logic [31:0] v);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(negedge i_ref_clk);
    v = o_rdata;
  endtask

  task automatic host_op(input op_t op, input logic [31:0] a, input logic [15:0] b,
      input logic [31:0] res, input logic [31:0] rem, input logic ov);
    logic [31:0] v;
    int k;
    hwr(HREG_OPA, a);
    hwr(HREG_OPB, {16'h0000, b});
    hwr(HREG_CTRL, 32'h0000_0100 | 32'(op));
    v = 32'h0000_0000;
    k = 0;
    while (v[HSTAT_DONE_BIT] !== 1'b1 && k < 60) begin
      hrd(HREG_STAT, v);
      k++;
    end
    chk(32'(v[HSTAT_DONE_BIT]), 32'h0000_0001);
    chk(32'(v[HSTAT_OV_BIT]), 32'(ov));
    chk(32'(v[HSTAT_ERR_BIT]), 32'h0000_0000);
    if (!ov) begin
      hrd(HREG_RES, v);
      chk(v, res);
      if (op != OP_MUL) begin
        hrd(HREG_REM, v);
        chk(v, rem);
      end
    end
  endtask

  task automatic t_host_ops();
    host_op(OP_MUL, 32'h0000_00ff, 16'h0101, 32'h0000_ffff, 32'h0, 1'b0);
    host_op(OP_MUL, 32'h0000_0100, 16'h0100, 32'h0, 32'h0, 1'b1);
    host_op(OP_DIV32, 32'h1234_5678, 16'h00ab, 32'h1234_5678 / 32'h0000_00ab,
      32'h1234_5678 % 32'h0000_00ab, 1'b0);
    host_op(OP_DIV32, 32'h1234_5678, 16'h0000, 32'h0, 32'h0, 1'b1);
    host_op(OP_DIV16, 32'h0000_9876, 16'h0123, 32'h0000_9876 / 32'h0000_0123,
      32'h0000_9876 % 32'h0000_0123, 1'b0);
    host_op(OP_DIV16, 32'h0000_9876, 16'h0000, 32'h0, 32'h0, 1'b1);
  endtask

  task automatic t_regs();
    bchk(IDX_STATUS, 8'h00);
    bwr(IDX_STATUS, 8'hff);
    bchk(IDX_STATUS, 8'h00);
    bchk(3'h7, 8'h00);
  endtask

  // Multiply with status and unmapped reads slipped between the operand writes.
  task automatic t_mul_gaps();
    logic [7:0] v;
    logic [31:0] p;
    int n;
    p = 32'h0000_1234 * 32'h0000_0102;
    bwr(3'h0, 8'h34);
    brd(IDX_STATUS, v);
    bwr(3'h4, 8'h02);
    bwr(3'h1, 8'h12);
    brd(3'h7, v);
    bwr(3'h5, 8'h01);
    busy_len(n);
    chk(32'(n), 32'(CYC_MUL));
    bchk(IDX_STATUS, 8'h40);
    for (int i = 0; i < 4; i++) begin
      bchk(3'(i), p[8*i+:8]);
      brd(IDX_STATUS, v);
    end
  endtask

  task automatic t_bad_order();
    int n;
    bwr(3'h0, 8'h11);
    bwr(3'h4, 8'h22);
    bwr(3'h5, 8'h33);
    busy_len(n);
    chk(32'(n), 32'h0000_0000);
    bwr(3'h0, 8'h34);
    bwr(3'h1, 8'h12);
    bwr(3'h4, 8'h00);
    bwr(3'h5, 8'h01);
    busy_len(n);
    chk(32'(n), 32'(CYC_DIV16));
    bchk(IDX_STATUS, 8'h00);
    bchk(3'h0, 8'h12);
    bchk(3'h1, 8'h00);
    bchk(3'h4, 8'h34);
    bchk(3'h5, 8'h00);
  endtask

  // Long divide with a read and a write while busy; the write must be dropped.
  task automatic t_busy_access();
    logic [7:0] v;
    logic [31:0] q;
    logic [31:0] r;
    int n;
    q = 32'h8765_4321 / 32'h0000_1234;
    r = 32'h8765_4321 % 32'h0000_1234;
    bwr(3'h0, 8'h21);
    bwr(3'h1, 8'h43);
    bwr(3'h2, 8'h65);
    bwr(3'h3, 8'h87);
    bwr(3'h4, 8'h34);
    bwr(3'h5, 8'h12);
    brd(3'h2, v);
    bwr(3'h1, 8'hee);
    bchk(IDX_STATUS, 8'h80);
    chk(32'(err_b), 32'h0000_0001);
    busy_len(n);
    bchk(IDX_STATUS, 8'h80);
    bchk(IDX_STATUS, 8'h00);
    for (int i = 0; i < 4; i++) begin
      bchk(3'(i), q[8*i+:8]);
    end
    bchk(3'h4, r[7:0]);
    bchk(3'h5, r[15:8]);
  endtask

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    i_rst = 1'b1;
    i_addr = 3'h0;
    i_wdata = 32'h0000_0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    bus_b.addr = 3'h0;
    bus_b.wdata = 8'h00;
    bus_b.wr = 1'b0;
    bus_b.rd = 1'b0;
    repeat (16) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_regs();
    t_mul_gaps();
    t_bad_order();
    t_busy_access();
    t_host_ops();
    tally_and_finish();
  end
endmodule
